// [hdtc_ctrl.v]
// Control registers for backplane slots and the framer, plus the transmit FIFO.
// Assumes a synchronous host strobe port and bit-serial datapath on clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "hdtc_regs.vh"
module hdtc_ctrl #(
   parameter FIFO_DEPTH = `HDTC_FIFO_DEPTH,
   parameter FIFO_AW = 5
)
(
   // Clock and reset
   input wire clk_sys,
   input wire nrst,
   // Host port
   input wire host_cs,
   input wire host_wr,
   input wire host_rd,
   input wire [4:0] host_addr,
   input wire [7:0] host_wdata,
   output reg [7:0] host_rdata,
   output reg host_tx_full,
   // Mode inputs
   input wire no_host,
   input wire nt_mode,
   input wire dchan_request,
   // Backplane slot data, one byte per slot per frame
   input wire [7:0] slot0_rx,
   input wire [7:0] slot1_rx,
   input wire [7:0] slot2_rx,
   input wire [7:0] slot3_rx,
   output reg [7:0] slot0_in,
   output reg [7:0] slot1_in,
   output reg [7:0] slot2_in,
   output reg [7:0] slot3_in,
   output reg [3:0] slot_out_oe,
   // Serial D-channel bits
   input wire bp_rx_bit,
   input wire line_rx_bit,
   input wire framer_tx_bit,
   output reg bp_tx_bit,
   output reg line_tx_bit,
   output reg framer_rx_bit,
   // Framer controls
   output reg framer_tx_on,
   output reg framer_rx_on,
   output reg addr_match_on,
   output reg interframe_fill_sel,
   output reg transparent_on,
   output reg rx_fifo_clear,
   output reg rx_hold_to_flag,
   output reg line_rx_off,
   // Transmit FIFO drain
   input wire tx_take,
   output reg tx_byte_valid,
   output reg [7:0] tx_byte,
   output reg tx_byte_abort,
   output reg tx_byte_end,
   output reg tx_fifo_empty
);
   // ********************************************
   // Register file
   // ********************************************
   reg [7:0] master_reg;
   reg [7:0] bus_channel_enables_reg;
   reg [7:0] hdlc_control_one_reg;
   reg [4:0] hdlc_control_two_reg;
   reg [7:0] line_receiver_control_reg;
   wire wr_en;
   wire rd_en;
   wire tx_push;
   wire gate_open;
   wire [7:0] ch_en;
   wire f_ready;
   wire f_valid;
   wire f_empty;
   wire [9:0] f_data;
   reg [7:0] rdata_next;
   assign wr_en = host_cs & host_wr;
   assign rd_en = host_cs & host_rd;
   assign gate_open = master_reg[`HDTC_BIT_MASTER_GATE];
   assign tx_push = wr_en & (host_addr == `HDTC_ADDR_TXFIFO);
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         master_reg <= `HDTC_RESET_VAL;
         bus_channel_enables_reg <= `HDTC_RESET_VAL;
         hdlc_control_one_reg <= `HDTC_RESET_VAL;
         hdlc_control_two_reg <= 5'h00;
         line_receiver_control_reg <= `HDTC_RESET_VAL;
      end
      else
      begin
         if (wr_en && host_addr == `HDTC_ADDR_MASTER)
            master_reg <= host_wdata;
         if (wr_en && host_addr == `HDTC_ADDR_BUSCH)
            bus_channel_enables_reg <= host_wdata;
         if (wr_en && host_addr == `HDTC_ADDR_CTL1)
            hdlc_control_one_reg <= host_wdata & `HDTC_CTL1_USED;
         if (wr_en && host_addr == `HDTC_ADDR_LINE && gate_open)
            line_receiver_control_reg <= host_wdata;
         if (wr_en && host_addr == `HDTC_ADDR_CTL2)
         begin
            // Clear strobes act in the write cycle and are not stored, so bits read back as done.
            hdlc_control_two_reg[`HDTC_BIT_TRANS] <= host_wdata[`HDTC_BIT_TRANS];
            hdlc_control_two_reg[`HDTC_BIT_RX_CLR] <= 1'b0;
            hdlc_control_two_reg[`HDTC_BIT_TX_CLR] <= 1'b0;
            hdlc_control_two_reg[`HDTC_BIT_ABORT] <= host_wdata[`HDTC_BIT_ABORT];
            hdlc_control_two_reg[`HDTC_BIT_END] <= host_wdata[`HDTC_BIT_END];
         end
         else if (tx_push && f_ready)
         begin
            hdlc_control_two_reg[`HDTC_BIT_ABORT] <= 1'b0;
            hdlc_control_two_reg[`HDTC_BIT_END] <= 1'b0;
         end
      end
   end
   // ********************************************
   // Host read path
   // ********************************************
   always @*
   begin
      rdata_next = 8'h00;
      case (host_addr)
         `HDTC_ADDR_MASTER: rdata_next = master_reg;
         `HDTC_ADDR_BUSCH: rdata_next = bus_channel_enables_reg;
         `HDTC_ADDR_CTL1: rdata_next = hdlc_control_one_reg;
         default: rdata_next = 8'h00;
      endcase
   end
   // ********************************************
   // Transmit FIFO with abort and end tags
   // ********************************************
   wire [7:0] clr_bits;
   wire rx_clr_pulse;
   wire tx_clr_pulse;
   assign clr_bits = host_wdata;
   assign rx_clr_pulse = wr_en & (host_addr == `HDTC_ADDR_CTL2) & clr_bits[`HDTC_BIT_RX_CLR];
   assign tx_clr_pulse = wr_en & (host_addr == `HDTC_ADDR_CTL2) & clr_bits[`HDTC_BIT_TX_CLR];
   hdtc_fifo #(
      .WIDTH(10),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_txf (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .flush(tx_clr_pulse),
      .in_valid(tx_push),
      .in_ready(f_ready),
      .in_data({hdlc_control_two_reg[`HDTC_BIT_ABORT], hdlc_control_two_reg[`HDTC_BIT_END], host_wdata}),
      .out_valid(f_valid),
      .out_ready(tx_take & tx_byte_valid),
      .out_data(f_data),
      .empty(f_empty)
   );
   // ********************************************
   // Slot gating and D-channel routing
   // ********************************************
   // no host enables all
   assign ch_en = no_host ? 8'hFF : bus_channel_enables_reg;
   wire tx_src;
   wire rx_src;
   wire loop_on;
   assign loop_on = hdlc_control_one_reg[`HDTC_BIT_LOOP];
   assign tx_src = hdlc_control_one_reg[`HDTC_BIT_TX_ON] ? framer_tx_bit : 1'b1;
   // receive port select, loopback, disabled reads ones
   assign rx_src = !hdlc_control_one_reg[`HDTC_BIT_RX_ON] ? 1'b1 :
                   loop_on ? tx_src :
                   hdlc_control_one_reg[`HDTC_BIT_RX_PORT] ? line_rx_bit : bp_rx_bit;
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         host_rdata <= 8'h00;
         host_tx_full <= 1'b0;
         slot0_in <= 8'hFF;
         slot1_in <= 8'h00;
         slot2_in <= 8'hFF;
         slot3_in <= 8'hFF;
         slot_out_oe <= 4'h0;
         bp_tx_bit <= 1'b1;
         line_tx_bit <= 1'b1;
         framer_rx_bit <= 1'b1;
         framer_tx_on <= 1'b0;
         framer_rx_on <= 1'b0;
         addr_match_on <= 1'b0;
         interframe_fill_sel <= 1'b0;
         transparent_on <= 1'b0;
         rx_fifo_clear <= 1'b0;
         rx_hold_to_flag <= 1'b0;
         line_rx_off <= 1'b0;
         tx_byte_valid <= 1'b0;
         tx_byte <= 8'h00;
         tx_byte_abort <= 1'b0;
         tx_byte_end <= 1'b0;
         tx_fifo_empty <= 1'b1;
      end
      else
      begin
         if (rd_en)
            host_rdata <= rdata_next;
         host_tx_full <= ~f_ready;
         slot3_in <= ch_en[7] ? slot3_rx : 8'hFF;
         slot2_in <= ch_en[6] ? slot2_rx : 8'hFF;
         slot0_in <= ch_en[4] ? slot0_rx : 8'hFF;
         slot1_in <= ch_en[5] ? slot1_rx : 8'h00;
         slot_out_oe <= ch_en[3:0];
         // transmit port select, terminal line in loopback needs request
         line_tx_bit <= (hdlc_control_one_reg[`HDTC_BIT_TX_PORT] &&
                         (!loop_on || nt_mode || dchan_request)) ? tx_src : 1'b1;
         bp_tx_bit <= hdlc_control_one_reg[`HDTC_BIT_TX_PORT] ? 1'b1 : tx_src;
         framer_rx_bit <= rx_src;
         framer_tx_on <= hdlc_control_one_reg[`HDTC_BIT_TX_ON];
         framer_rx_on <= hdlc_control_one_reg[`HDTC_BIT_RX_ON];
         addr_match_on <= hdlc_control_one_reg[`HDTC_BIT_ADDR_MATCH];
         interframe_fill_sel <= hdlc_control_one_reg[`HDTC_BIT_FILL];
         transparent_on <= hdlc_control_two_reg[`HDTC_BIT_TRANS];
         rx_fifo_clear <= rx_clr_pulse;
         if (rx_clr_pulse)
            rx_hold_to_flag <= 1'b1;
         else if (rx_src == 1'b0 || transparent_on)
            rx_hold_to_flag <= 1'b0;
         line_rx_off <= line_receiver_control_reg[`HDTC_BIT_LINE_RX_OFF];
         tx_byte_valid <= f_valid & ~tx_clr_pulse & ~(tx_take & tx_byte_valid);
         tx_byte <= f_data[7:0];
         tx_byte_end <= f_data[8];
         tx_byte_abort <= f_data[9];
         tx_fifo_empty <= f_empty;
      end
   end
endmodule
`default_nettype wire

// [hdtc_ctrl_asserts.sv]
// Checker bound onto the control block, watching its ports only.
// Assumes one clock and an asynchronous active low reset.
`timescale 1ns/1ns
`default_nettype none
module hdtc_ctrl_chk
(
   // Clock, reset and strobes
   input wire logic clk_sys, nrst, host_cs, host_wr, host_rd, no_host, tx_take,
   // Outputs under watch, with the address, data and slot inputs they follow
   input wire logic rx_fifo_clear, tx_fifo_empty, tx_byte_valid, framer_tx_on,
   input wire logic [4:0] host_addr,
   input wire logic [7:0] host_wdata, host_rdata, slot0_rx, slot0_in, slot1_in,
   input wire logic [3:0] slot_out_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wire w = host_cs && host_wr;
   wire w1 = w && host_addr == 5'h01;
   wire w2 = w && host_addr == 5'h02;
   wire w3 = w && host_addr == 5'h03;
   wire w4 = w && host_addr == 5'h04;
   slot_on_a:
   assert property (w1 && host_wdata[4] ##1 !w1 [*2] |=> slot0_in == $past(slot0_rx)) else $error("slot0 stale");
   slot_off_a:
   assert property (w1 && !host_wdata[5] ##1 (!w1 && !no_host) [*2] |=> slot1_in == 8'h00) else $error("slot1 open");
   slot_oe_a:
   assert property (w1 ##1 (!w1 && !no_host) [*2] |=> slot_out_oe == $past(host_wdata[3:0], 3)) else $error("oe wrong");
   no_host_a:
   assert property (no_host [*3] |-> slot_out_oe == 4'hF) else $error("oe not forced");
   tx_on_a:
   assert property (w2 ##1 !w2 [*2] |-> framer_tx_on == $past(host_wdata[7], 2)) else $error("tx enable wrong");
   rx_clr_a:
   assert property (w3 && host_wdata[3] |=> ##[0:1] rx_fifo_clear) else $error("no rx clear");
   tx_clr_a:
   assert property (w3 && host_wdata[2] ##1 !w4 |=> tx_fifo_empty && !tx_byte_valid) else $error("fifo kept");
   wo_read_a:
   assert property (host_cs && host_rd && (host_addr == 5'h03 || host_addr == 5'h10) |=> host_rdata == 8'h00)
      else $error("write-only read");
   cover property (w3 && host_wdata[2]);
   cover property (tx_take && tx_byte_valid);
   cover property (rx_fifo_clear);
endmodule
bind hdtc_ctrl hdtc_ctrl_chk chk_i (.*);
`default_nettype wire

// [hdtc_fifo.v]
// Tag-carrying transmit byte FIFO in flip-flops.
// Assumes one clock; flush has priority over push and pop.
`timescale 1ns/1ns
`default_nettype none
module hdtc_fifo #(
   parameter WIDTH = 10,
   parameter DEPTH = 32,
   parameter AW = 5
)
(
   // Clock, reset and flush
   input wire clk_sys,
   input wire nrst,
   input wire flush,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data,
   output wire empty
);
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] cnt_reg;
   wire push;
   wire pop;
   assign in_ready = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != {(AW+1){1'b0}});
   assign empty = ~out_valid;
   assign out_data = mem_reg[rd_reg];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk_sys)
   begin
      if (push)
         mem_reg[wr_reg] <= in_data;
   end
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end
      else if (flush)
      begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         cnt_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
         if (pop)
            rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
         if (push & ~pop)
            cnt_reg <= cnt_reg + 1'b1;
         else if (pop & ~push)
            cnt_reg <= cnt_reg - 1'b1;
      end
   end
endmodule
`default_nettype wire

// [hdtc_host.sv]
// Host model driving the control block's strobe port.
// Assumes the block samples strobes on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module hdtc_host
(
   // Clock
   input wire logic clk_sys,
   // Strobe port
   output var logic host_cs,
   output var logic host_wr,
   output var logic host_rd,
   output var logic [4:0] host_addr,
   output var logic [7:0] host_wdata
);
   initial
      {host_cs, host_wr, host_rd, host_addr, host_wdata} = 16'h0000;
   // One access held over its sampling edge, then one quiet cycle.
   task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = (a == 5'h02) ? 8'hFD : (a == 5'h03) ? 8'h1F : 8'hFF;
      @(posedge clk_sys);
      host_cs <= 1'b1;
      host_wr <= w;
      host_rd <= !w;
      host_addr <= a;
      host_wdata <= d & m;
      @(posedge clk_sys);
      host_cs <= 1'b0;
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      // Released data flips, so nothing can lean on a stale byte.
      host_wdata <= ~(d & m);
   endtask
endmodule
`default_nettype wire

// [hdtc_regs.vh]
// Register map constants for the channel and framer control block.
// Assumes inclusion by bare name from the design file.
// Operation
// - Input enables 3,2,0; disabled reads all ones
// - Input enable 1; disabled reads all zeros
// - Output enables; disabled slot goes high impedance
// - Without host, all slots enabled
// - Transmitter enable; off sends all ones
// - Receiver enable; off sees all ones
// - Address match keeps own or broadcast
// - Transmit port select: line or backplane
// - Receive port select: line or backplane
// - Fill between frames: flags or ones
// - Loopback feeds transmit into receive
// - Transparent mode: plain serial conversion only
// - Receive clear empties FIFO, self clears
// - Transmit clear discards FIFO, self clears
// - Abort tag marks next written byte
// - End tag marks next written byte
// - Tags clear after each FIFO write
// - Line receiver disable bit
// - Line control reachable only with master bit
`ifndef HDTC_REGS_VH
`define HDTC_REGS_VH
`define HDTC_ADDR_MASTER 5'h00
`define HDTC_ADDR_BUSCH 5'h01
`define HDTC_ADDR_CTL1 5'h02
`define HDTC_ADDR_CTL2 5'h03
`define HDTC_ADDR_TXFIFO 5'h04
`define HDTC_ADDR_LINE 5'h10
`define HDTC_BIT_MASTER_GATE 7
`define HDTC_BIT_TX_ON 7
`define HDTC_BIT_RX_ON 6
`define HDTC_BIT_ADDR_MATCH 5
`define HDTC_BIT_TX_PORT 4
`define HDTC_BIT_RX_PORT 3
`define HDTC_BIT_FILL 2
`define HDTC_BIT_LOOP 0
`define HDTC_BIT_TRANS 4
`define HDTC_BIT_RX_CLR 3
`define HDTC_BIT_TX_CLR 2
`define HDTC_BIT_ABORT 1
`define HDTC_BIT_END 0
`define HDTC_BIT_LINE_RX_OFF 6
`define HDTC_CTL1_USED 8'hFD
`define HDTC_CTL2_USED 8'h1F
`define HDTC_RESET_VAL 8'h00
`define HDTC_FIFO_DEPTH 32
`endif

// [tb.sv]
// Self-checking bench for the slot and framer control block.
// Assumes hdtc_host drives the strobes and the checker is bound in.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_sys = 1'b0, nrst = 1'b0, no_host = 1'b0, nt_mode = 1'b1, dchan_request = 1'b0;
   logic bp_rx_bit = 1'b0, line_rx_bit = 1'b0, framer_tx_bit = 1'b0, tx_take = 1'b0, t;
   logic [7:0] slot0_rx = 8'h00, slot1_rx = 8'h00, slot2_rx = 8'h00, slot3_rx = 8'h00, v, b;
   wire host_cs, host_wr, host_rd, host_tx_full, bp_tx_bit, line_tx_bit, framer_rx_bit;
   wire framer_tx_on, framer_rx_on, addr_match_on, interframe_fill_sel, transparent_on;
   wire rx_fifo_clear, line_rx_off, tx_byte_valid, tx_byte_abort, tx_byte_end, tx_fifo_empty, rx_hold_to_flag;
   wire [4:0] host_addr;
   wire [7:0] host_wdata, host_rdata, slot0_in, slot1_in, slot2_in, slot3_in, tx_byte;
   wire [3:0] slot_out_oe;
   logic [31:0] seed = 32'h11F7F468;
   logic [7:0] rq[$];
   logic [9:0] tq[$];
   logic rd_q = 1'b0;
   int miscompares = 0;
   int tests_run = 0;
   always #25 clk_sys = ~clk_sys;
   hdtc_host host (.*);
   hdtc_ctrl uut (.*);
   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task chk(input string n, input logic [9:0] e, input logic [9:0] g);
      tests_run++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task tally_and_finish();
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task rdx(input logic [4:0] a, input logic [7:0] e);
      rq.push_back(e);
      host.acc(1'b0, a, 8'h00);
   endtask
   task fw(input logic [9:0] e);
      tq.push_back(e);
      host.acc(1'b1, 5'h04, e[7:0]);
   endtask
   // The drain side stalls a cycle per byte, so refresh gaps are exercised.
   task take();
      logic [9:0] e;
      int n;
      e = tq.pop_front();
      n = 0;
      do
      begin
         @(negedge clk_sys);
         n++;
      end
      while (tx_byte_valid !== 1'b1 && n < 20);
      chk("tx_valid", 1'b1, tx_byte_valid);
      chk("tx_out", e, {tx_byte_abort, tx_byte_end, tx_byte});
      @(posedge clk_sys);
      tx_take <= 1'b1;
      @(posedge clk_sys);
      tx_take <= 1'b0;
   endtask
   always @(posedge clk_sys)
      rd_q <= host_cs & host_rd;
   always @(negedge clk_sys)
      if (rd_q)
         chk("host_rdata", rq.pop_front(), host_rdata);
   initial
   begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      rdx(5'h1F, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 8'hFF : (i == 7) ? 8'h00 : rnd();
         @(posedge clk_sys);
         slot0_rx <= rnd();
         slot1_rx <= rnd();
         slot2_rx <= rnd();
         slot3_rx <= rnd();
         host.acc(1'b1, 5'h01, v);
         rdx(5'h01, v);
         cyc(3);
         chk("s0", v[4] ? slot0_rx : 8'hFF, slot0_in);
         chk("s1", v[5] ? slot1_rx : 8'h00, slot1_in);
         chk("s2", v[6] ? slot2_rx : 8'hFF, slot2_in);
         chk("s3", v[7] ? slot3_rx : 8'hFF, slot3_in);
         chk("oe", v[3:0], slot_out_oe);
      end
      @(posedge clk_sys);
      no_host <= 1'b1;
      cyc(3);
      chk("oe", 8'h0F, slot_out_oe);
      chk("s1", slot1_rx, slot1_in);
      @(posedge clk_sys);
      no_host <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         v = (i == 0) ? 8'hFD : rnd() & 8'hFD;
         if (v[0])
            v[6] = 1'b1;
         b = rnd();
         @(posedge clk_sys);
         framer_tx_bit <= b[0];
         bp_rx_bit <= b[1];
         line_rx_bit <= b[2];
         host.acc(1'b1, 5'h02, v);
         rdx(5'h02, v);
         cyc(3);
         t = v[7] ? b[0] : 1'b1;
         chk("tx_on", v[7], framer_tx_on);
         chk("rx_on", v[6], framer_rx_on);
         chk("match", v[5], addr_match_on);
         chk("line_tx", v[4] ? t : 1'b1, line_tx_bit);
         chk("bp_tx", v[4] ? 1'b1 : t, bp_tx_bit);
         chk("rx_bit", !v[6] | (v[0] ? t : v[3] ? b[2] : b[1]), framer_rx_bit);
         chk("fill", v[2], interframe_fill_sel);
      end
      // Terminal mode with loopback: the line only carries data on request.
      @(posedge clk_sys);
      nt_mode <= 1'b0;
      framer_tx_bit <= 1'b0;
      host.acc(1'b1, 5'h02, 8'hD1);
      cyc(3);
      chk("line_tx", 1'b1, line_tx_bit);
      @(posedge clk_sys);
      dchan_request <= 1'b1;
      cyc(3);
      chk("line_tx", 1'b0, line_tx_bit);
      chk("rx_bit", 1'b0, framer_rx_bit);
      // Receive clear holds the receiver until a zero bit arrives.
      host.acc(1'b1, 5'h02, 8'h00);
      host.acc(1'b1, 5'h03, 8'h08);
      cyc(2);
      chk("hold", 1'b1, rx_hold_to_flag);
      @(posedge clk_sys);
      bp_rx_bit <= 1'b0;
      host.acc(1'b1, 5'h02, 8'h40);
      cyc(2);
      chk("hold", 1'b0, rx_hold_to_flag);
      host.acc(1'b1, 5'h03, 8'h01);
      fw(10'h1A5);
      fw(10'h05A);
      host.acc(1'b1, 5'h03, 8'h02);
      fw(10'h23C);
      repeat (3) take();
      for (int i = 0; i < 32; i++)
         host.acc(1'b1, 5'h04, rnd());
      cyc(1);
      chk("full", 1'b1, host_tx_full);
      host.acc(1'b1, 5'h03, 8'h04);
      cyc(2);
      chk("empty", 1'b1, tx_fifo_empty);
      chk("full", 1'b0, host_tx_full);
      host.acc(1'b1, 5'h03, 8'h18);
      cyc(3);
      chk("trans", 1'b1, transparent_on);
      rdx(5'h03, 8'h00);
      host.acc(1'b1, 5'h10, 8'h40);
      cyc(3);
      chk("rx_off", 1'b0, line_rx_off);
      host.acc(1'b1, 5'h00, 8'h80);
      host.acc(1'b1, 5'h10, 8'h40);
      cyc(3);
      chk("rx_off", 1'b1, line_rx_off);
      rdx(5'h10, 8'h00);
      cyc(3);
      tally_and_finish();
   end
   initial
   begin
      #2000000;
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
